// [cic_mst.sv]
`timescale 1ns/1ps
// Bus master model; it makes the clock and only ever pulls data low.
module cic_mst
  import cic_pkg::*;
(
  output logic scl,
  output logic pull_low,
  input wire logic sda
);
  // Idle bus: clock stands high, data is released.
  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // One bit: data moves while the clock is low and is sampled while high.
  task automatic bit_io(input logic b, output logic s);
    begin
      pull_low = ~b;
      #40 scl = 1'b1;
      #40 s = sda;
      #40 scl = 1'b0;
      #40;
    end
  endtask
  // Start, also usable as a repeated start from a low clock.
  task automatic start();
    begin
      pull_low = 1'b0;
      #40 scl = 1'b1;
      #40 pull_low = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
  endtask
  // Stop leaves the clock standing high.
  task automatic stop();
    begin
      pull_low = 1'b1;
      #40 scl = 1'b1;
      #40 pull_low = 1'b0;
      #80;
    end
  endtask
  // Sends a byte most significant bit first and samples the answer.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask
  // Receives a byte, then acknowledges or withholds it.
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        bit_io(1'b1, d[i]);
      bit_io(~ack, s);
    end
  endtask
endmodule

// [cic_pkg.sv]
package cic_pkg;
  // Device-type codes of the two logical targets.
  localparam logic [3:0] ID_MEM = 4'ha;
  localparam logic [3:0] ID_COMP = 4'hd;
  // Companion register offsets.
  localparam logic [7:0] REG_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] REG_CAL_CONTROL = 8'h01;
  localparam logic [7:0] REG_TIME_FIRST = 8'h02;
  localparam logic [7:0] REG_TIME_LAST = 8'h05;
  localparam logic [7:0] REG_LAST = 8'h18;
  // Field positions of clock_control and the calibration register.
  localparam int CC_READ = 0;
  localparam int CC_WRITE = 1;
  localparam int CC_CAL = 2;
  localparam int CC_CENTURY = 6;
  localparam int CAL_SIGN = 5;
  localparam int CAL_OSC = 7;
  // Writable bits, protected bits and reset values.
  localparam logic [7:0] CC_WMASK = 8'h47;
  localparam logic [7:0] CAL_LOCK_MASK = 8'h3f;
  localparam logic [7:0] CAL_FREE_MASK = 8'h80;
  localparam logic [7:0] CC_RESET = 8'h00;
  localparam logic [7:0] CAL_RESET = 8'h00;
  // Bit counter positions inside one byte frame.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Byte engine states.
  typedef enum logic [2:0] {
    ST_ADDR,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IDLE
  } cic_state_e;
  // Sampled bus line pair.
  typedef struct packed {
    logic scl;
    logic sda;
  } cic_line_s;
  // Register write request.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } cic_wr_s;
endpackage

// [cic_slave.sv]
`timescale 1ns/1ps
// Contract
// RULE1: Answer as memory target when the first byte's type nibble is 1010b.
// RULE2: Answer as companion target when the type nibble is 1101b.
// RULE3: Slave only; never drive the clock, move data only under master clocks.
// RULE4: Detect stop as data rising while clock is high.
// RULE5: A stop aborts any operation in progress.
// RULE6: Detect start as data falling while clock is high, at any moment.
// RULE7: A start aborts the operation and awaits a new address byte.
// RULE8: The master opens every command with a start.
// RULE9: The master closes every operation with a stop.
// RULE10: Supply below trip level aborts the transaction; master restarts.
// RULE11: Bits are sampled on clock high; data stays stable then.
// RULE12: One acknowledge slot follows each eighth bit; transmitter releases data.
// RULE13: Low in the slot acknowledges; high is no-acknowledge and aborts.
// RULE14: After a no-acknowledge the device is ready to be addressed again.
// RULE15: A read keeps sending bytes while the master acknowledges each.
// RULE16: The master ends a read by not acknowledging the final byte.
// RULE17: Five-bit trim is writable only while calibration mode is one.
// RULE18: Address bits 2..1 match select pins; bit 0 one means read.
// RULE19: Companion addresses above 18h get no-acknowledge and abort.
// RULE20: Trim sign is writable only while calibration mode is one.
// RULE21: Read bit rising copies running time into readable holding registers.
// RULE22: Write bit holds user time; clearing it loads the running counters.
module cic_slave
  import cic_pkg::*;
#(
  parameter logic [7:0] MEM_FILL = 8'hff
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] sel_pins,
  input wire logic supply_trip,
  input wire logic [31:0] tk_count,
  output logic tk_load,
  output logic [31:0] tk_load_val,
  output logic [7:0] trim_setting
);

  // Core clock domain state.
  cic_line_s line_m, line_s, line_p;
  logic trip_m, trip_s, abort_q, next_abort;
  logic snap_m, snap_s, snap_p;
  logic wup_m, wup_s, wup_p;
  logic [31:0] hold, next_hold, next_load_val;
  logic next_load, start_det, stop_det;
  logic link_rst;

  // Link clock domain state.
  cic_state_e state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, tx, next_tx, byte_in;
  logic ack_me, next_ack, mem, next_mem, acnt, next_acnt;
  logic oe_q, next_oe, hit;
  logic [1:0] sel_m, sel_s;
  logic [7:0] addr, next_addr, cc, next_cc, cal, next_cal, toff;
  logic [7:0] ut [4];
  logic [7:0] next_ut [4];
  logic snap_tog, next_snap_tog;
  cic_wr_s wr;

  // Picks one companion register for a read; time bytes come from hold.
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input logic [7:0] c,
                                          input logic [7:0] k,
                                          input logic [31:0] h);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      REG_CLOCK_CONTROL: r = c;
      REG_CAL_CONTROL: r = k;
      8'h02: r = h[7:0];
      8'h03: r = h[15:8];
      8'h04: r = h[23:16];
      REG_TIME_LAST: r = h[31:24];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Bus conditions, trip level and snapshot and load requests, core side.
  always_comb
  begin
    start_det = line_p.scl & line_s.scl & line_p.sda & ~line_s.sda; // RULE6
    stop_det = line_p.scl & line_s.scl & ~line_p.sda & line_s.sda; // RULE4
    next_abort = start_det | stop_det | trip_s; // RULE5 RULE7 RULE10
    next_hold = (snap_s != snap_p) ? tk_count : hold; // RULE21
    next_load = wup_p & ~wup_s; // RULE22
    next_load_val = next_load ? {ut[3], ut[2], ut[1], ut[0]} : tk_load_val;
  end

  // Synchronisers and core registers; edge detection compares the second and third stages.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      line_m <= '{scl: 1'b1, sda: 1'b1};
      line_s <= '{scl: 1'b1, sda: 1'b1};
      line_p <= '{scl: 1'b1, sda: 1'b1};
      trip_m <= 1'b0;
      trip_s <= 1'b0;
      abort_q <= 1'b0;
      snap_m <= 1'b0;
      snap_s <= 1'b0;
      snap_p <= 1'b0;
      wup_m <= 1'b0;
      wup_s <= 1'b0;
      wup_p <= 1'b0;
      hold <= 32'h0000_0000;
      tk_load <= 1'b0;
      tk_load_val <= 32'h0000_0000;
    end
    else
    begin
      line_m <= '{scl: scl, sda: sda_in};
      line_s <= line_m;
      line_p <= line_s;
      trip_m <= supply_trip;
      trip_s <= trip_m;
      abort_q <= next_abort;
      snap_m <= snap_tog;
      snap_s <= snap_m;
      snap_p <= snap_s;
      wup_m <= cc[CC_WRITE];
      wup_s <= wup_m;
      wup_p <= wup_s;
      hold <= next_hold;
      tk_load <= next_load;
      tk_load_val <= next_load_val;
    end
  end

  // A start, stop or trip resets the byte engine asynchronously.
  assign link_rst = sys_rst | abort_q;

  // The pin is open drain: only ever pulled low, never the clock.
  assign sda_out = 1'b0; // RULE3
  assign sda_oe = oe_q;
  assign trim_setting = cal;

  // Byte engine, register writes and the line drive, link side.
  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_tx = tx;
    next_ack = ack_me;
    next_mem = mem;
    next_acnt = acnt;
    next_addr = addr;
    next_cc = cc;
    next_cal = cal;
    next_ut = ut;
    wr = '0;
    byte_in = {shreg[6:0], sda_in}; // RULE11
    hit = ((byte_in[7:4] == ID_MEM) || (byte_in[7:4] == ID_COMP)) &&
          (byte_in[2:1] == sel_s); // RULE1 RULE2 RULE18
    toff = addr - REG_TIME_FIRST;
    if (bitcnt != BIT_ACK)
    begin
      next_shreg = byte_in;
      next_bitcnt = bitcnt + 4'h1;
      if (state == ST_RDATA)
        next_tx = {tx[6:0], 1'b0};
      if (bitcnt == BIT_LAST)
      begin
        case (state)
          ST_ADDR:
            if (hit)
            begin
              next_ack = 1'b1;
              next_mem = (byte_in[7:4] == ID_MEM); // RULE1
              next_acnt = 1'b0;
              next_state = byte_in[0] ? ST_RDATA : ST_WADDR; // RULE18
            end
            else
              next_state = ST_IDLE;
          ST_WADDR:
            if (mem)
            begin
              next_ack = 1'b1;
              next_acnt = 1'b1;
              if (acnt)
                next_state = ST_WDATA;
            end
            else if (byte_in <= REG_LAST)
            begin
              next_ack = 1'b1;
              next_addr = byte_in;
              next_state = ST_WDATA;
            end
            else
              next_state = ST_IDLE; // RULE19
          ST_WDATA:
          begin
            next_ack = 1'b1;
            if (!mem)
            begin
              wr = '{en: 1'b1, addr: addr, data: byte_in}; // RULE2
              next_addr = addr + 8'h01;
            end
          end
          default: next_state = state;
        endcase
      end
    end
    else
    begin
      next_bitcnt = 4'h0;
      next_ack = 1'b0;
      if (state == ST_RDATA)
      begin
        if (sda_in)
          next_state = ST_IDLE; // RULE13 RULE14
        else
        begin
          next_tx = mem ? MEM_FILL : read_reg(addr, cc, cal, hold); // RULE15
          if (!mem)
            next_addr = addr + 8'h01;
        end
      end
    end
    if (wr.en)
    begin
      case (wr.addr)
        REG_CLOCK_CONTROL: next_cc = wr.data & CC_WMASK;
        REG_CAL_CONTROL:
          if (cc[CC_CAL])
            next_cal = wr.data & (CAL_LOCK_MASK | CAL_FREE_MASK);
          else
            next_cal = (cal & CAL_LOCK_MASK) |
                       (wr.data & CAL_FREE_MASK); // RULE17 RULE20
        default:
          if ((wr.addr >= REG_TIME_FIRST) && (wr.addr <= REG_TIME_LAST))
            next_ut[toff[1:0]] = wr.data; // RULE22
      endcase
    end
    next_snap_tog = snap_tog ^ (~cc[CC_READ] & next_cc[CC_READ]); // RULE21
    next_oe = (ack_me && (bitcnt == BIT_ACK)) ||
              ((state == ST_RDATA) && (bitcnt != BIT_ACK) && !tx[7]); // RULE12
  end

  // Engine registers; cleared by any bus abort.
  always_ff @(posedge scl or posedge link_rst)
  begin
    if (link_rst)
    begin
      state <= ST_ADDR; // RULE7
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'hff;
      ack_me <= 1'b0;
      mem <= 1'b0;
      acnt <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      tx <= next_tx;
      ack_me <= next_ack;
      mem <= next_mem;
      acnt <= next_acnt;
    end
  end

  // Registers that survive bus aborts, plus the select pin synchroniser.
  always_ff @(posedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr <= 8'h00;
      cc <= CC_RESET;
      cal <= CAL_RESET;
      ut <= '{default: 8'h00};
      snap_tog <= 1'b0;
      sel_m <= 2'b00;
      sel_s <= 2'b00;
    end
    else
    begin
      addr <= next_addr;
      cc <= next_cc;
      cal <= next_cal;
      ut <= next_ut;
      snap_tog <= next_snap_tog;
      sel_m <= sel_pins;
      sel_s <= sel_m;
    end
  end

  // The line changes on the falling clock edge, or at once when an abort clears it.
  always_ff @(negedge scl or posedge link_rst)
  begin
    if (link_rst)
      oe_q <= 1'b0;
    else
      oe_q <= next_oe;
  end

  // Checks on bus conditions, core side.
  a_start_abort: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE7
    start_det |=> abort_q && link_rst)
    else $error("start did not abort the engine");
  a_stop_abort: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE5
    stop_det |=> abort_q)
    else $error("stop did not abort the engine");
  a_trip_abort: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
    trip_m |=> ##1 link_rst)
    else $error("supply trip did not abort the engine");

  // Named steps of a byte frame, link side.
  sequence s_addr_hit;
    (state == ST_ADDR) && (bitcnt == BIT_LAST) && hit;
  endsequence
  sequence s_ack_slot;
    ack_me && (bitcnt == BIT_ACK);
  endsequence

  a_addr_ack: assert property (@(posedge scl) disable iff (link_rst) // RULE1
    s_addr_hit |=> s_ack_slot ##1 (bitcnt == 4'h0) && !ack_me)
    else $error("matching address not acknowledged for one slot");
  a_range_nack: assert property (@(posedge scl) disable iff (link_rst) // RULE19
    ((state == ST_WADDR) && !mem && (bitcnt == BIT_LAST) &&
     (byte_in > REG_LAST)) |=> (state == ST_IDLE) && !ack_me)
    else $error("address above 18h was acknowledged");
  a_trim_lock: assert property (@(posedge scl) disable iff (sys_rst) // RULE17
    (wr.en && (wr.addr == REG_CAL_CONTROL) && !cc[CC_CAL]) |=>
    (cal[5:0] == $past(cal[5:0])))
    else $error("trim changed outside calibration mode");
  a_read_nack: assert property (@(posedge scl) disable iff (link_rst) // RULE13
    ((state == ST_RDATA) && (bitcnt == BIT_ACK) && sda_in) |=>
    (state == ST_IDLE) ##1 !oe_q)
    else $error("read went on after no-acknowledge");
  a_read_next: assert property (@(posedge scl) disable iff (link_rst) // RULE15
    ((state == ST_RDATA) && (bitcnt == BIT_ACK) && !sda_in) |=>
    (state == ST_RDATA) && (bitcnt == 4'h0))
    else $error("read stopped despite acknowledge");
  a_idle_quiet: assert property (@(negedge scl) disable iff (link_rst) // RULE14
    (state == ST_IDLE) |=> !oe_q)
    else $error("line driven while not addressed");

endmodule

// [tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the two-wire slave front end.
module tb;
  import cic_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] sel_pins = 2'h0;
  logic supply_trip = 1'b0;
  logic [31:0] tk_count = 32'h44332211;
  logic scl, pull_low, sda_out, sda_oe, tk_load;
  logic [31:0] tk_load_val;
  logic [7:0] trim_setting;
  wire sda = ~(pull_low | (sda_oe & ~sda_out));
  int failures = 0;
  int comparisons = 0;
  int loads = 0;
  // Core clock and a count of load pulses.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (tk_load === 1'b1)
      loads <= loads + 1;
  cic_slave #(.MEM_FILL(8'h5a)) i_cic_slave (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sel_pins(sel_pins),
    .supply_trip(supply_trip), .tk_count(tk_count), .tk_load(tk_load),
    .tk_load_val(tk_load_val), .trim_setting(trim_setting));
  cic_mst i_mst (.scl(scl), .pull_low(pull_low), .sda(sda));
  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    begin
      comparisons++;
      if (g !== e)
      begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Sends a byte and checks the acknowledge.
  task automatic ab(input logic [7:0] d, input logic e);
    logic a;
    begin
      i_mst.wr(d, a);
      chk("ack", {31'h0, e}, {31'h0, a});
    end
  endtask
  // Reads a byte and checks it.
  task automatic rb(input logic ack, input logic [7:0] e);
    logic [7:0] v;
    begin
      i_mst.rd(ack, v);
      chk("rdata", {24'h0, e}, {24'h0, v});
    end
  endtask
  // Writes one companion register.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    begin
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(a, 1'b1);
      ab(d, 1'b1);
      i_mst.stop();
    end
  endtask
  // Reads two companion registers after a repeated start.
  task automatic rreg(input logic [7:0] a, input logic [7:0] e0,
    input logic [7:0] e1);
    begin
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(a, 1'b1);
      i_mst.start();
      ab(8'hd1, 1'b1);
      rb(1'b1, e0);
      rb(1'b0, e1);
      i_mst.stop();
      chk("oe", 32'h0, {31'h0, sda_oe});
    end
  endtask
  // Trim locked, then writable in calibration mode; snapshot reads.
  task automatic t_trim();
    begin
      chk("trim", 32'h0, {24'h0, trim_setting});
      wreg(8'h01, 8'ha5);
      chk("trim", 32'h80, {24'h0, trim_setting});
      wreg(8'h00, 8'h04);
      wreg(8'h01, 8'ha5);
      chk("trim", 32'ha5, {24'h0, trim_setting});
      wreg(8'h00, 8'h05);
      repeat (10) @(negedge core_clk);
      rreg(8'h01, 8'ha5, 8'h11);
      rreg(8'h04, 8'h33, 8'h44);
      rreg(8'h00, 8'h05, 8'ha5);
      // Bit 7 is reserved and reads zero; the century flag is kept.
      wreg(8'h00, 8'hc4);
      rreg(8'h00, 8'h44, 8'ha5);
      wreg(8'h00, 8'h04);
    end
  endtask
  // Time update loads the counters only when the write bit clears.
  task automatic t_upd();
    begin
      wreg(8'h00, 8'h06);
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(8'h02, 1'b1);
      ab(8'h78, 1'b1);
      ab(8'h56, 1'b1);
      ab(8'h34, 1'b1);
      ab(8'h12, 1'b1);
      i_mst.stop();
      chk("load", 32'h0, loads);
      wreg(8'h00, 8'h04);
      repeat (10) @(negedge core_clk);
      chk("load", 32'h1, loads);
      chk("loadval", 32'h12345678, tk_load_val);
    end
  endtask
  // Target codes, select bits, memory fill and register range.
  task automatic t_addr();
    logic [8:0] tab [4] = '{9'h1a0, 9'h0d2, 9'h0b0, 9'h0d6};
    begin
      foreach (tab[i])
      begin
        i_mst.start();
        ab(tab[i][7:0], tab[i][8]);
        i_mst.stop();
      end
      @(negedge core_clk);
      sel_pins = 2'h3;
      i_mst.start();
      ab(8'ha7, 1'b1);
      rb(1'b0, 8'h5a);
      i_mst.stop();
      @(negedge core_clk);
      sel_pins = 2'h0;
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(8'h18, 1'b1);
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(8'h19, 1'b0);
      ab(8'h00, 1'b0);
      i_mst.stop();
      wreg(8'h01, 8'ha5);
    end
  endtask
  // Stop, start and supply trip abort a transfer in progress.
  task automatic t_abort();
    logic s;
    begin
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(8'h01, 1'b1);
      repeat (4) i_mst.bit_io(1'b0, s);
      i_mst.stop();
      chk("trim", 32'ha5, {24'h0, trim_setting});
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(8'h01, 1'b1);
      repeat (4) i_mst.bit_io(1'b0, s);
      i_mst.start();
      ab(8'hd0, 1'b1);
      ab(8'h01, 1'b1);
      ab(8'h25, 1'b1);
      i_mst.stop();
      chk("trim", 32'h25, {24'h0, trim_setting});
      i_mst.start();
      ab(8'hd0, 1'b1);
      @(negedge core_clk);
      supply_trip = 1'b1;
      repeat (10) @(negedge core_clk);
      supply_trip = 1'b0;
      repeat (10) @(negedge core_clk);
      ab(8'h01, 1'b0);
      i_mst.stop();
      i_mst.start();
      ab(8'hd0, 1'b1);
      i_mst.stop();
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    begin
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("oe", 32'h0, {31'h0, sda_oe});
    t_trim();
    t_upd();
    t_addr();
    t_abort();
    finish_test();
  end
  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge core_clk);
    failures++;
    $display("MISMATCH timeout expected done seen hang");
    finish_test();
  end
endmodule
